// ### hw/arf_pkg.sv
package arf_pkg;

	// general-purpose register indices (operand encoding order)
	localparam logic [2:0] ARF_GPR_ACCUMULATOR       = 3'h0;
	localparam logic [2:0] ARF_GPR_LOOP_COUNTER      = 3'h1;
	localparam logic [2:0] ARF_GPR_IO_POINTER        = 3'h2;
	localparam logic [2:0] ARF_GPR_DATA_BASE_POINTER = 3'h3;
	localparam logic [2:0] ARF_GPR_STACK_POINTER     = 3'h4;
	localparam logic [2:0] ARF_GPR_FRAME_POINTER     = 3'h5;
	localparam logic [2:0] ARF_GPR_SOURCE_INDEX      = 3'h6;
	localparam logic [2:0] ARF_GPR_TARGET_INDEX      = 3'h7;
	localparam int         ARF_GPR_COUNT             = 8;
	// highest index that has byte views
	localparam logic [2:0] ARF_BYTE_VIEW_MAX         = 3'h3;

	// segment register indices
	localparam logic [2:0] ARF_SEG_EXTRA       = 3'h0;
	localparam logic [2:0] ARF_SEG_CODE        = 3'h1;
	localparam logic [2:0] ARF_SEG_STACK       = 3'h2;
	localparam logic [2:0] ARF_SEG_DATA        = 3'h3;
	localparam logic [2:0] ARF_SEG_THIRD_DATA  = 3'h4;
	localparam logic [2:0] ARF_SEG_FOURTH_DATA = 3'h5;
	localparam int         ARF_SEG_COUNT       = 6;

	// reset values and offset limits
	localparam logic [31:0] ARF_GPR_RESET  = 32'h0000_0000;
	localparam logic [15:0] ARF_SEG_RESET  = 16'h0000;
	localparam logic [31:0] ARF_IP_RESET   = 32'h0000_0000;
	localparam logic [31:0] ARF_MAX_OFF32  = 32'hFFFF_FFFF;
	localparam logic [31:0] ARF_MAX_OFF16  = 32'h0000_FFFF;

	typedef enum logic [0:0] {
		ARF_MODE_REAL = 1'b0,
		ARF_MODE_PROT = 1'b1
	} arf_mode_t;

	typedef enum logic [2:0] {
		ARF_VIEW_32   = 3'b000,
		ARF_VIEW_16   = 3'b001,
		ARF_VIEW_8LO  = 3'b010,
		ARF_VIEW_8HI  = 3'b011,
		ARF_VIEW_SEG  = 3'b100
	} arf_view_t;

	typedef struct packed {
		arf_view_t  view;
		logic [2:0] idx;
	} arf_opsel_t;

	typedef struct packed {
		logic        valid;
		logic        base_en;
		logic [2:0]  base;
		logic        index_en;
		logic [2:0]  index;
		logic [1:0]  scale;
		logic [31:0] disp;
		logic        seg_ovr_en;
		logic [2:0]  seg_ovr;
	} arf_ea_req_t;

	typedef struct packed {
		logic [15:0] sel;
		logic [31:0] off;
	} arf_far_ptr_t;

endpackage

// ### hw/arf_regfile.sv
// Notes on behaviour
// (RULE1) 32-bit size allows full 32-bit offsets
// (RULE2) 16-bit size limits offsets to 16 bits
// (RULE3) far pointer: selector plus sized offset
// (RULE4) prefixes override sizes for one instruction
// (RULE5) protected mode: code descriptor sets defaults
// (RULE6) real mode: defaults are 16-bit
// (RULE7) real-mode 32-bit addresses still capped 16-bit; only o_ea_fault enforces it, stack and string offsets stay 32-bit
// (RULE8) eight 32-bit general-purpose registers
// (RULE9) low 16-bit alias of each register
// (RULE10) byte views for first four registers only
// (RULE11) six 16-bit segment selector registers
// (RULE12) software loads selectors before segment access
// (RULE13) fetch uses code selector and instruction pointer
// (RULE14) code selector loads only by control transfer
// (RULE15) stack operations go through stack selector
// (RULE16) four independent data segment selectors
// (RULE17) string ops use counter, source, target implicitly
// (RULE18) default segments follow the pointer register
// (RULE19) alias writes keep the other bits
// (RULE20) reset starts in real mode
module arf_regfile (
	// clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst_n,
	// mode control
	input  wire logic                  i_mode_wr,
	input  wire arf_pkg::arf_mode_t    i_mode,
	input  wire logic                  i_cs_desc_32,
	// per-instruction size prefixes
	input  wire logic                  i_addr_ovr,
	input  wire logic                  i_opnd_ovr,
	// operand write port
	input  wire logic                  i_wr_en,
	input  wire arf_pkg::arf_opsel_t   i_wr_sel,
	input  wire logic [31:0]           i_wr_data,
	// control transfer
	input  wire logic                  i_xfer_en,
	input  wire logic [15:0]           i_xfer_sel,
	input  wire logic [31:0]           i_xfer_ip,
	// instruction pointer advance
	input  wire logic                  i_ip_adv,
	input  wire logic [3:0]            i_ip_step,
	// operand read ports
	input  wire arf_pkg::arf_opsel_t   i_rd_a_sel,
	input  wire arf_pkg::arf_opsel_t   i_rd_b_sel,
	// effective address request
	input  wire arf_pkg::arf_ea_req_t  i_ea_req,
	// read data
	output logic [31:0]                o_rd_a_data,
	output logic [31:0]                o_rd_b_data,
	// write status
	output logic                       o_wr_refused,
	// size state
	output arf_pkg::arf_mode_t         o_mode,
	output logic                       o_addr32,
	output logic                       o_opnd32,
	// address results
	output logic                       o_ea_valid,
	output logic                       o_ea_fault,
	output arf_pkg::arf_far_ptr_t      o_ea_ptr,
	output arf_pkg::arf_far_ptr_t      o_fetch_ptr,
	output arf_pkg::arf_far_ptr_t      o_stack_ptr,
	output arf_pkg::arf_far_ptr_t      o_str_src_ptr,
	output arf_pkg::arf_far_ptr_t      o_str_dst_ptr,
	output logic [31:0]                o_str_count
);

	logic                rst_sync1_q;
	logic                rst_sync2_q;
	logic                rst_n;
	arf_pkg::arf_mode_t  mode_q;
	logic [31:0]         gpr_q [arf_pkg::ARF_GPR_COUNT];
	logic [15:0]         seg_q [arf_pkg::ARF_SEG_COUNT];
	logic [31:0]         ip_q;
	logic                def32_c;
	logic                addr32_c;
	logic                opnd32_c;
	logic                gpr_wr_ok_c;
	logic                seg_wr_ok_c;
	logic [31:0]         ea_raw_c;
	logic [2:0]          ea_seg_c;
	logic [31:0]         ip_next_c;

	// offset limited to the active address size
	function automatic logic [31:0] size_mask(input logic [31:0] v, input logic a32);
		size_mask = a32 ? (v & arf_pkg::ARF_MAX_OFF32) : (v & arf_pkg::ARF_MAX_OFF16); // RULE1 RULE2
	endfunction

	// merge a write through a view into the full register
	function automatic logic [31:0] view_merge(input logic [31:0] old,
			input arf_pkg::arf_view_t view, input logic [31:0] data);
		view_merge = old;
		unique case (view)
			arf_pkg::ARF_VIEW_32:  view_merge = data;
			arf_pkg::ARF_VIEW_16:  view_merge[15:0] = data[15:0]; // RULE9 RULE19
			arf_pkg::ARF_VIEW_8LO: view_merge[7:0] = data[7:0]; // RULE10 RULE19
			arf_pkg::ARF_VIEW_8HI: view_merge[15:8] = data[7:0]; // RULE10 RULE19
			default:               view_merge = old;
		endcase
	endfunction

	// extract a view, zero-extended
	function automatic logic [31:0] view_read(input logic [31:0] r, input logic [15:0] s,
			input arf_pkg::arf_opsel_t sel);
		view_read = 32'h0000_0000;
		unique case (sel.view)
			arf_pkg::ARF_VIEW_32:  view_read = r;
			arf_pkg::ARF_VIEW_16:  view_read = {16'h0000, r[15:0]}; // RULE9
			arf_pkg::ARF_VIEW_8LO: view_read = (sel.idx <= arf_pkg::ARF_BYTE_VIEW_MAX) ?
				{24'h00_0000, r[7:0]} : 32'h0000_0000; // RULE10
			arf_pkg::ARF_VIEW_8HI: view_read = (sel.idx <= arf_pkg::ARF_BYTE_VIEW_MAX) ?
				{24'h00_0000, r[15:8]} : 32'h0000_0000; // RULE10
			arf_pkg::ARF_VIEW_SEG: view_read = (sel.idx < 3'h6) ? {16'h0000, s} : 32'h0000_0000;
			default:               view_read = 32'h0000_0000;
		endcase
	endfunction

	// segment read with out-of-range index guarded
	function automatic logic [2:0] seg_idx(input logic [2:0] idx);
		seg_idx = (idx < 3'h6) ? idx : arf_pkg::ARF_SEG_DATA;
	endfunction

	// reset release through two flip-flops
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end
	assign rst_n = rst_sync2_q;

	// operating mode
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= arf_pkg::ARF_MODE_REAL; // RULE20
		end else if (i_mode_wr) begin
			mode_q <= i_mode;
		end
	end

	// default and effective sizes
	always_comb begin
		def32_c  = (mode_q == arf_pkg::ARF_MODE_PROT) ? i_cs_desc_32 : 1'b0; // RULE5 RULE6
		addr32_c = def32_c ^ i_addr_ovr; // RULE4
		opnd32_c = def32_c ^ i_opnd_ovr; // RULE4
	end

	// write legality
	always_comb begin
		gpr_wr_ok_c = 1'b0;
		seg_wr_ok_c = 1'b0;
		unique case (i_wr_sel.view)
			arf_pkg::ARF_VIEW_32,
			arf_pkg::ARF_VIEW_16:  gpr_wr_ok_c = 1'b1;
			arf_pkg::ARF_VIEW_8LO,
			arf_pkg::ARF_VIEW_8HI: gpr_wr_ok_c = (i_wr_sel.idx <= arf_pkg::ARF_BYTE_VIEW_MAX); // RULE10
			arf_pkg::ARF_VIEW_SEG: seg_wr_ok_c = (i_wr_sel.idx < 3'h6) &&
				(i_wr_sel.idx != arf_pkg::ARF_SEG_CODE); // RULE14
			default:               gpr_wr_ok_c = 1'b0;
		endcase
	end

	// general-purpose registers
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < arf_pkg::ARF_GPR_COUNT; i++) begin
				gpr_q[i] <= arf_pkg::ARF_GPR_RESET;
			end
		end else if (i_wr_en && gpr_wr_ok_c) begin
			gpr_q[i_wr_sel.idx] <= view_merge(gpr_q[i_wr_sel.idx], i_wr_sel.view, i_wr_data); // RULE8
		end
	end

	// segment selectors
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < arf_pkg::ARF_SEG_COUNT; i++) begin
				seg_q[i] <= arf_pkg::ARF_SEG_RESET;
			end
		end else begin
			if (i_wr_en && seg_wr_ok_c) begin
				seg_q[i_wr_sel.idx] <= i_wr_data[15:0]; // RULE11 RULE15 RULE16
			end
			if (i_xfer_en) begin
				seg_q[arf_pkg::ARF_SEG_CODE] <= i_xfer_sel; // RULE14
			end
		end
	end

	// instruction pointer
	always_comb begin
		ip_next_c = size_mask(ip_q + {28'h000_0000, i_ip_step}, def32_c);
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ip_q <= arf_pkg::ARF_IP_RESET;
		end else if (i_xfer_en) begin
			ip_q <= i_xfer_ip; // RULE14
		end else if (i_ip_adv) begin
			ip_q <= ip_next_c; // RULE13
		end
	end

	// write refusal flag
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_wr_refused <= 1'b0;
		end else begin
			o_wr_refused <= i_wr_en && !gpr_wr_ok_c && !seg_wr_ok_c; // RULE14
		end
	end

	// operand reads
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rd_a_data <= 32'h0000_0000;
			o_rd_b_data <= 32'h0000_0000;
		end else begin
			o_rd_a_data <= view_read(gpr_q[i_rd_a_sel.idx], seg_q[seg_idx(i_rd_a_sel.idx)],
				i_rd_a_sel);
			o_rd_b_data <= view_read(gpr_q[i_rd_b_sel.idx], seg_q[seg_idx(i_rd_b_sel.idx)],
				i_rd_b_sel);
		end
	end

	// size state outputs
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_mode   <= arf_pkg::ARF_MODE_REAL; // RULE20
			o_addr32 <= 1'b0;
			o_opnd32 <= 1'b0;
		end else begin
			o_mode   <= mode_q;
			o_addr32 <= addr32_c; // RULE4
			o_opnd32 <= opnd32_c; // RULE4
		end
	end

	// effective address and its segment
	always_comb begin
		ea_raw_c = i_ea_req.disp;
		if (i_ea_req.base_en) begin
			ea_raw_c = ea_raw_c + gpr_q[i_ea_req.base];
		end
		if (i_ea_req.index_en) begin
			ea_raw_c = ea_raw_c + (gpr_q[i_ea_req.index] << i_ea_req.scale);
		end
		if (i_ea_req.seg_ovr_en) begin
			ea_seg_c = seg_idx(i_ea_req.seg_ovr); // RULE12 RULE16
		end else if (i_ea_req.base_en &&
				(i_ea_req.base == arf_pkg::ARF_GPR_STACK_POINTER ||
				i_ea_req.base == arf_pkg::ARF_GPR_FRAME_POINTER)) begin
			ea_seg_c = arf_pkg::ARF_SEG_STACK; // RULE18
		end else begin
			ea_seg_c = arf_pkg::ARF_SEG_DATA; // RULE18
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_ea_valid <= 1'b0;
			o_ea_fault <= 1'b0;
			o_ea_ptr   <= '0;
		end else begin
			o_ea_valid   <= i_ea_req.valid;
			o_ea_fault   <= i_ea_req.valid && addr32_c && (mode_q == arf_pkg::ARF_MODE_REAL) &&
				(ea_raw_c > arf_pkg::ARF_MAX_OFF16); // RULE7
			o_ea_ptr.sel <= seg_q[ea_seg_c]; // RULE3
			o_ea_ptr.off <= size_mask(ea_raw_c, addr32_c); // RULE3
		end
	end

	// implicit pointers: fetch, stack, string
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_fetch_ptr   <= '0;
			o_stack_ptr   <= '0;
			o_str_src_ptr <= '0;
			o_str_dst_ptr <= '0;
			o_str_count   <= 32'h0000_0000;
		end else begin
			o_fetch_ptr.sel   <= seg_q[arf_pkg::ARF_SEG_CODE]; // RULE13
			o_fetch_ptr.off   <= ip_q; // RULE13
			o_stack_ptr.sel   <= seg_q[arf_pkg::ARF_SEG_STACK]; // RULE15
			o_stack_ptr.off   <= size_mask(gpr_q[arf_pkg::ARF_GPR_STACK_POINTER], addr32_c);
			o_str_src_ptr.sel <= seg_q[arf_pkg::ARF_SEG_DATA]; // RULE18
			o_str_src_ptr.off <= size_mask(gpr_q[arf_pkg::ARF_GPR_SOURCE_INDEX], addr32_c); // RULE17
			o_str_dst_ptr.sel <= seg_q[arf_pkg::ARF_SEG_EXTRA]; // RULE18
			o_str_dst_ptr.off <= size_mask(gpr_q[arf_pkg::ARF_GPR_TARGET_INDEX], addr32_c); // RULE17
			o_str_count       <= size_mask(gpr_q[arf_pkg::ARF_GPR_LOOP_COUNTER], addr32_c); // RULE17
		end
	end

endmodule

// ### verification/arf_regfile_chk.sv
module arf_regfile_chk (
	// clock and reset
	input wire logic                  i_core_clk,
	input wire logic                  i_rst_n,
	// watched inputs
	input wire logic                  i_mode_wr,
	input wire logic                  i_cs_desc_32,
	input wire logic                  i_addr_ovr,
	input wire logic                  i_wr_en,
	input wire arf_pkg::arf_opsel_t   i_wr_sel,
	input wire logic                  i_xfer_en,
	input wire logic [15:0]           i_xfer_sel,
	input wire logic [31:0]           i_xfer_ip,
	input wire logic                  i_ip_adv,
	input wire arf_pkg::arf_ea_req_t  i_ea_req,
	// watched outputs
	input wire logic                  o_wr_refused,
	input wire arf_pkg::arf_mode_t    o_mode,
	input wire logic                  o_addr32,
	input wire logic                  o_ea_valid,
	input wire logic                  o_ea_fault,
	input wire arf_pkg::arf_far_ptr_t o_ea_ptr,
	input wire arf_pkg::arf_far_ptr_t o_fetch_ptr
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// mode settled for three cycles with no mode load
	sequence s_real_held;
		(o_mode == arf_pkg::ARF_MODE_REAL && !i_mode_wr) [*3];
	endsequence
	sequence s_prot_held;
		(o_mode == arf_pkg::ARF_MODE_PROT && !i_mode_wr) [*3];
	endsequence
	sequence s_xfer_quiet;
		i_xfer_en ##1 (!i_xfer_en && !i_ip_adv);
	endsequence
	property p_ref_byte;
		i_wr_en && i_wr_sel.view inside {arf_pkg::ARF_VIEW_8LO, arf_pkg::ARF_VIEW_8HI}
			&& i_wr_sel.idx > 3'h3 |=> o_wr_refused;
	endproperty
	a_ref_byte: assert property (p_ref_byte) else $error("byte write not refused");
	property p_ref_code;
		i_wr_en && i_wr_sel.view == arf_pkg::ARF_VIEW_SEG && i_wr_sel.idx == 3'h1 |=> o_wr_refused;
	endproperty
	a_ref_code: assert property (p_ref_code) else $error("code load not refused");
	property p_real16;
		s_real_held ##0 !i_addr_ovr |=> !o_addr32;
	endproperty
	a_real16: assert property (p_real16) else $error("real mode not 16-bit");
	property p_real_ovr;
		s_real_held ##0 i_addr_ovr |=> o_addr32;
	endproperty
	a_real_ovr: assert property (p_real_ovr) else $error("prefix ignored");
	property p_prot32;
		s_prot_held ##0 (i_cs_desc_32 && !i_addr_ovr) |=> o_addr32;
	endproperty
	a_prot32: assert property (p_prot32) else $error("descriptor size ignored");
	property p_ea16;
		o_ea_valid && !o_addr32 |-> o_ea_ptr.off[31:16] == 16'h0000;
	endproperty
	a_ea16: assert property (p_ea16) else $error("16-bit offset not limited");
	property p_fault;
		s_real_held ##0 (i_ea_req.valid && i_addr_ovr && !i_ea_req.base_en
			&& !i_ea_req.index_en && i_ea_req.disp > 32'h0000_FFFF) |=> o_ea_fault;
	endproperty
	a_fault: assert property (p_fault) else $error("real mode offset not capped");
	property p_fetch;
		s_xfer_quiet |=> o_fetch_ptr == {$past(i_xfer_sel, 2), $past(i_xfer_ip, 2)};
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch pointer not loaded");
endmodule

// ### verification/arf_regfile_bench.sv
module arf_regfile_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {int stamp; logic [3:0] kind; logic [48:0] val;} arf_note_t;
	logic                  i_core_clk, i_rst_n, i_mode_wr, i_cs_desc_32, i_addr_ovr, i_opnd_ovr;
	logic                  i_wr_en, i_xfer_en, i_ip_adv, o_wr_refused, o_addr32, o_opnd32;
	logic                  o_ea_valid, o_ea_fault;
	logic [3:0]            i_ip_step;
	logic [15:0]           i_xfer_sel;
	logic [31:0]           i_wr_data, i_xfer_ip, o_rd_a_data, o_rd_b_data, o_str_count;
	arf_pkg::arf_mode_t    i_mode, o_mode;
	arf_pkg::arf_opsel_t   i_wr_sel, i_rd_a_sel, i_rd_b_sel;
	arf_pkg::arf_ea_req_t  i_ea_req;
	arf_pkg::arf_far_ptr_t o_ea_ptr, o_fetch_ptr, o_stack_ptr, o_str_src_ptr, o_str_dst_ptr;
	logic [31:0]           gpr [8];
	logic [15:0]           seg [6];
	arf_note_t             q [$];
	int                    cyc, mismatches, comparisons;
	arf_regfile u_dut (.i_core_clk, .i_rst_n, .i_mode_wr, .i_mode, .i_cs_desc_32, .i_addr_ovr,
		.i_opnd_ovr, .i_wr_en, .i_wr_sel, .i_wr_data, .i_xfer_en, .i_xfer_sel, .i_xfer_ip,
		.i_ip_adv, .i_ip_step, .i_rd_a_sel, .i_rd_b_sel, .i_ea_req, .o_rd_a_data,
		.o_rd_b_data, .o_wr_refused, .o_mode, .o_addr32, .o_opnd32, .o_ea_valid, .o_ea_fault,
		.o_ea_ptr, .o_fetch_ptr, .o_stack_ptr, .o_str_src_ptr, .o_str_dst_ptr, .o_str_count);
	initial i_core_clk = 1'b0;
	always #20 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) cyc <= cyc + 1;
	function automatic logic [48:0] obs(input logic [3:0] k);
		case (k)
			4'h0: return {17'h0, o_rd_a_data};
			4'h1: return {o_ea_fault, o_ea_ptr};
			4'h2: return {1'b0, o_fetch_ptr};
			4'h3: return {46'h0, o_mode, o_addr32, o_opnd32};
			4'h4: return {48'h0, o_wr_refused};
			4'h5: return {1'b0, o_stack_ptr};
			4'h6: return {1'b0, o_str_src_ptr};
			4'h7: return {1'b0, o_str_dst_ptr};
			4'h8: return {17'h0, o_str_count};
			4'hA: return {17'h0, o_rd_b_data};
			default: return {47'h0, o_ea_valid, o_ea_fault};
		endcase
	endfunction
	// notes from earlier cycles are due once a rising edge has passed
	always @(negedge i_core_clk) begin
		arf_note_t n;
		while (q.size() > 0 && q[0].stamp < cyc) begin
			n = q.pop_front();
			comparisons++;
			if (obs(n.kind) !== n.val) begin
				$display("ERROR t=%0t exp=%h got=%h", $time, n.val, obs(n.kind));
				mismatches++;
			end
		end
	end
	task automatic ex(input logic [3:0] k, input logic [48:0] v);
		q.push_back('{cyc, k, v});
	endtask
	function automatic logic [31:0] rv(input logic [2:0] v, input logic [2:0] x);
		case (v)
			3'h0: return gpr[x];
			3'h1: return {16'h0, gpr[x][15:0]};
			3'h2: return x > 3 ? 32'h0 : {24'h0, gpr[x][7:0]};
			3'h3: return x > 3 ? 32'h0 : {24'h0, gpr[x][15:8]};
			default: return x > 5 ? 32'h0 : {16'h0, seg[x]};
		endcase
	endfunction
	task automatic rd(input logic [2:0] v, input logic [2:0] x);
		@(negedge i_core_clk);
		i_rd_a_sel = {v, x};
		i_rd_b_sel = {3'h0, ~x};
		ex(4'h0, {17'h0, rv(v, x)});
		ex(4'hA, {17'h0, rv(3'h0, ~x)});
	endtask
	task automatic wr(input logic [2:0] v, input logic [2:0] x, input logic [31:0] d);
		logic r;
		r = (v inside {3'h2, 3'h3} && x > 3) || (v == 3'h4 && (x == 1 || x > 5));
		@(negedge i_core_clk);
		i_wr_en = 1'b1;
		i_wr_sel = {v, x};
		i_wr_data = d;
		ex(4'h4, {48'h0, r});
		if (!r) case (v)
			3'h0: gpr[x] = d;
			3'h1: gpr[x][15:0] = d[15:0];
			3'h2: gpr[x][7:0] = d[7:0];
			3'h3: gpr[x][15:8] = d[7:0];
			default: seg[x] = d[15:0];
		endcase
		rd(v, x);
		i_wr_en = 1'b0;
	endtask
	task automatic md(input logic m, input logic d, input logic a, input logic o);
		@(negedge i_core_clk);
		i_mode = arf_pkg::arf_mode_t'(m);
		i_mode_wr = 1'b1;
		{i_cs_desc_32, i_addr_ovr, i_opnd_ovr} = {d, a, o};
		@(negedge i_core_clk);
		i_mode_wr = 1'b0;
		@(negedge i_core_clk);
	endtask
	task automatic ea(input arf_pkg::arf_ea_req_t r, input logic [31:0] m);
		logic [31:0] o;
		logic [15:0] s;
		o = r.disp + (r.base_en ? gpr[r.base] : 0) + (r.index_en ? gpr[r.index] << r.scale : 0);
		s = r.seg_ovr_en ? (r.seg_ovr > 5 ? seg[3] : seg[r.seg_ovr])
			: (r.base_en && r.base inside {3'h4, 3'h5}) ? seg[2] : seg[3];
		@(negedge i_core_clk);
		i_ea_req = r;
		ex(4'h1, {1'b0, s, o & m});
		@(negedge i_core_clk);
		i_ea_req.valid = 1'b0;
	endtask
	task automatic end_of_test();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{i_rst_n, i_mode_wr, i_cs_desc_32, i_addr_ovr, i_opnd_ovr, i_wr_en, i_xfer_en} = '0;
		{i_ip_adv, i_ip_step, i_xfer_sel, i_xfer_ip, i_wr_data, i_ea_req} = '0;
		{i_mode, i_wr_sel, i_rd_a_sel, i_rd_b_sel} = '0;
		gpr = '{default: 32'h0};
		seg = '{default: 16'h0};
		void'($urandom(38));
		repeat (8) @(negedge i_core_clk);
		i_rst_n = 1'b1;
		repeat (3) @(negedge i_core_clk);
		ex(4'h3, 49'h0);
		for (int i = 0; i < 8; i++) wr(3'h0, 3'(i), $urandom);
		for (int i = 0; i < 8; i++) begin
			wr(3'h1, 3'(i), $urandom);
			wr(3'h2, 3'(i), $urandom);
			wr(3'h3, 3'(i), $urandom);
			rd(3'h0, 3'(i));
			wr(3'h4, 3'(i), $urandom);
		end
		@(negedge i_core_clk);
		{i_xfer_en, i_xfer_sel, i_xfer_ip} = {1'b1, 16'(($urandom)), 32'h0000_FFFE};
		seg[1] = i_xfer_sel;
		@(negedge i_core_clk);
		i_xfer_en = 1'b0;
		ex(4'h2, {1'b0, seg[1], 32'h0000_FFFE});
		rd(3'h4, 3'h1);
		{i_ip_adv, i_ip_step} = {1'b1, 4'h3};
		@(negedge i_core_clk);
		i_ip_adv = 1'b0;
		@(negedge i_core_clk);
		ex(4'h2, {1'b0, seg[1], 32'h0000_0001});
		for (int i = 0; i < 8; i++) begin
			md(i[2], i[1], i[0], ~i[0]);
			ex(4'h3, {46'h0, i[2], (i[2] & i[1]) ^ i[0], (i[2] & i[1]) ^ ~i[0]});
		end
		for (int s = 0; s < 2; s++) begin
			logic [31:0] m;
			m = s ? 32'hFFFF_FFFF : 32'h0000_FFFF;
			md(1'b1, s[0], 1'b0, 1'b0);
			ex(4'h5, {1'b0, seg[2], gpr[4] & m});
			ex(4'h6, {1'b0, seg[3], gpr[6] & m});
			ex(4'h7, {1'b0, seg[0], gpr[7] & m});
			ex(4'h8, {17'h0, gpr[1] & m});
			ea('{1, 1, 6, 1, 3, 2, $urandom, 0, 0}, m);
			ea('{1, 1, 5, 0, 0, 0, 32'h4, 0, 0}, m);
			for (int j = 4; j < 7; j++) ea('{1, 0, 0, 0, 0, 0, 32'h10, 1, j}, m);
		end
		// mid-run reset from protected mode falls back to real mode
		@(negedge i_core_clk);
		i_rst_n = 1'b0;
		gpr = '{default: 32'h0};
		seg = '{default: 16'h0};
		@(negedge i_core_clk);
		i_rst_n = 1'b1;
		repeat (3) @(negedge i_core_clk);
		ex(4'h3, 49'h0);
		rd(3'h0, 3'h0);
		md(1'b0, 1'b0, 1'b1, 1'b0);
		repeat (3) @(negedge i_core_clk);
		for (int f = 0; f < 2; f++) begin
			@(negedge i_core_clk);
			i_ea_req = '{1, 0, 0, 0, 0, 0, f ? 32'h0001_0000 : 32'h0000_FFFF, 0, 0};
			ex(4'h9, {47'h0, 1'b1, f[0]});
		end
		@(negedge i_core_clk);
		i_ea_req.valid = 1'b0;
		for (int k = 0; k < 20 && q.size() > 0; k++) @(negedge i_core_clk);
		if (q.size() > 0) mismatches++;
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge i_core_clk);
		mismatches++;
		end_of_test();
	end
endmodule
bind arf_regfile arf_regfile_chk u_chk (.i_core_clk, .i_rst_n, .i_mode_wr, .i_cs_desc_32,
	.i_addr_ovr, .i_wr_en, .i_wr_sel, .i_xfer_en, .i_xfer_sel, .i_xfer_ip, .i_ip_adv,
	.i_ea_req, .o_wr_refused, .o_mode, .o_addr32, .o_ea_valid, .o_ea_fault, .o_ea_ptr,
	.o_fetch_ptr);
